// [rtl/malc_top.sv]
// Memory access and lock control: CPU and debug port routing, fuses, lock and stores.
`timescale 1ns/1ps
`default_nettype none
`include "malc_map.svh"
// Summary of operation
// (R1) Flash is delivered as 16-bit words to instruction fetch.
// (R2) Program counter is 11 bits wide, covering the whole program memory.
// (R3) Flash at 0x8000 for normal loads/stores, 0x0000 for program-memory loads.
// (R4) EEPROM is read and written one byte at a time.
// (R5) Full erase leaves the user configuration page unchanged.
// (R6) Three identification bytes live in a separate signature space.
// (R7) Locked debug port may only reach the system information block; the code also passes its user page writes and full erase.
// (R8) Short I/O form reaches addresses 0x00 to 0x3F only.
// (R9) Extended I/O 0x0040 to 0x0FFF only through general loads and stores.
// (R10) Bit set/clear on 0x00-0x1F changes just the addressed bit.
// (R11) Software writes reserved bits as zero and avoids reserved addresses.
// (R12) Four byte stores from 0x1C, each resetting to 0x00.
// (R13) Lock blocks debug reads; CPU accesses keep working.
// (R14) Any lock key value other than the valid key means locked.
// (R15) Locked debug reads complete without error but return invalid data.
// (R16) Locked debug may write, but not read, the user configuration page.
// (R17) Only a full erase unlocks, and it destroys application data.
// (R18) Both sides read fuses; only the debug port programs them.
// (R19) Fuse values are copied to target registers at end of start-up.
// (R20) Changed fuses take effect only after the next reset.
// (R21) Host writes reserved fuse bits as one.
// (R22) User page is byte-wide, CPU always, debug reads while unlocked and writes always.
// (R23) Signature writes ignored from both sides; CPU fuse writes ignored.
module malc_top
  import malc_pkg::*;
#(
  parameter int PC_W = 11,
  parameter int NUM_FUSES = 11,
  parameter int USER_BYTES = 32,
  parameter logic [7:0] LOCK_KEY = 8'hC5,
  parameter logic [23:0] SIG_VALUE = 24'h5A0102, // Arbitrary value.
  parameter logic [31:0] SIB_VALUE = 32'h00A1B2C3 // Arbitrary value.
)(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire malc_req_s cpu_req,
  output logic cpu_ready,
  output logic cpu_rvalid,
  output logic [7:0] cpu_rdata,
  input wire malc_req_s dbg_req,
  output logic dbg_ready,
  output logic dbg_rvalid,
  output logic [7:0] dbg_rdata,
  input wire logic dbg_erase,
  input wire logic fetch_en,
  input wire logic [PC_W-1:0] fetch_pc,
  output logic [PC_W-1:0] fetch_addr,
  input wire logic [15:0] fetch_word_in,
  output logic fetch_valid,
  output logic [15:0] fetch_word,
  output malc_mem_s mem_req,
  input wire logic [7:0] mem_rdata,
  output logic mem_erase,
  output logic [NUM_FUSES-1:0][7:0] cfg_out,
  output logic locked,
  output logic started
);
  localparam int FW = $clog2(NUM_FUSES);
  localparam int UW = $clog2(USER_BYTES);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (PC_W < 1 || PC_W > 15) begin : g_bad_pc
    $error("PC_W must lie in 1..15");
  end
  if (NUM_FUSES <= `MALC_FUSE_LOCK_IDX || NUM_FUSES > 16) begin : g_bad_fuse
    $error("NUM_FUSES must hold the lock field and be at most 16");
  end
  if (USER_BYTES < 2 || (1 << UW) != USER_BYTES) begin : g_bad_user
    $error("USER_BYTES must be a power of two");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  malc_state_e state_reg;
  logic [FW-1:0] load_idx_reg;
  logic [NUM_FUSES-1:0][7:0] fuse_reg;
  logic [USER_BYTES-1:0][7:0] user_reg;
  logic [3:0][7:0] gps_val;
  logic locked_reg;
  logic cpu_act, dbg_act, act_go, act_dbg, erase_go;
  malc_req_s act_req;
  malc_route_s rt;
  logic [7:0] int_data;
  logic gps_wr, gps_bit, fuse_wr, user_wr;
  logic p1_valid, p1_dbg;
  malc_src_e p1_src;
  logic [7:0] p1_data;

  // ---------------------------------------------------------------
  // Routing function
  // ---------------------------------------------------------------
  // Decides where one access goes; writes are screened separately, so a refused
  // CPU fuse or signature write is still routed to its source and simply disappears.
  function automatic malc_route_s route(input malc_req_s r, input logic from_dbg,
                                        input logic lck);
    malc_route_s o;
    malc_op_e op;
    o = '{src: SRC_NONE, addr: r.addr, flash: 1'b0};
    op = from_dbg ? OP_NORMAL : r.op;
    case (r.space)
      SP_SIB: o.src = from_dbg ? SRC_SIB : SRC_NONE;
      SP_SIG: o.src = (r.addr < 16'(`MALC_SIG_BYTES)) ? SRC_SIG : SRC_NONE;
      SP_FUSE: o.src = (r.addr < 16'(NUM_FUSES)) ? SRC_FUSE : SRC_NONE;
      SP_USER: o.src = (r.addr < 16'(USER_BYTES)) ? SRC_USER : SRC_NONE;
      SP_DATA: begin
        case (op)
          // (R3) Program-memory load base.
          OP_PMLOAD: begin
            o.src = SRC_MEM;
            o.flash = 1'b1;
            o.addr = r.addr - `MALC_PMLOAD_BASE;
          end
          // (R8) Short I/O range only.
          OP_IO_SHORT: begin
            if (r.addr <= `MALC_IO_SHORT_LAST) begin
              // Only 0x1C..0x1F are stores; the rest of the short range is ordinary I/O.
              o.src = (r.addr >= `MALC_GPS_BASE && r.addr <= `MALC_BIT_IO_LAST) ? SRC_GPS : SRC_MEM;
            end
          end
          OP_BIT_SET, OP_BIT_CLR: begin
            if (r.addr <= `MALC_BIT_IO_LAST) begin
              o.src = (r.addr >= `MALC_GPS_BASE) ? SRC_GPS : SRC_MEM;
            end
          end
          // (R3) Load/store flash window.
          // (R9) Extended I/O passes through.
          OP_NORMAL: begin
            if (r.addr >= `MALC_FLASH_LDST_BASE) begin
              o.src = SRC_MEM;
              o.flash = 1'b1;
              o.addr = r.addr - `MALC_FLASH_LDST_BASE;
            end else if (r.addr >= `MALC_GPS_BASE && r.addr <= `MALC_BIT_IO_LAST) begin
              o.src = SRC_GPS;
            end else begin
              o.src = SRC_MEM;
            end
          end
          default: o.src = SRC_NONE;
        endcase
      end
      default: o.src = SRC_NONE;
    endcase
    // (R7) Locked debug: info block only.
    // (R16) User page writes still pass.
    if (from_dbg && lck && r.space != SP_SIB && !(r.space == SP_USER && r.wr)) begin
      o.src = r.rd ? SRC_BLOCK : SRC_NONE;
    end
    return o;
  endfunction

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  // The CPU always wins the shared path; the debug port waits one cycle at
  // a time, which keeps the running application free of extra stalls.
  always_comb begin
    cpu_act = cpu_req.rd | cpu_req.wr;
    dbg_act = dbg_req.rd | dbg_req.wr;
    cpu_ready = started;
    dbg_ready = started & ~cpu_act;
    act_dbg = ~cpu_act;
    act_req = cpu_act ? cpu_req : dbg_req;
    act_go = started & (cpu_act | dbg_act);
    erase_go = started & dbg_erase;
    // (R13) CPU route ignores lock.
    rt = route(act_req, act_dbg, locked_reg);
  end

  // ---------------------------------------------------------------
  // Write screening
  // ---------------------------------------------------------------
  always_comb begin
    gps_bit = act_go & ~act_dbg & act_req.wr & rt.src == SRC_GPS &
              (act_req.op == OP_BIT_SET || act_req.op == OP_BIT_CLR);
    gps_wr = act_go & act_req.wr & rt.src == SRC_GPS & ~gps_bit;
    // (R18) Fuse writes from debug only.
    // (R23) CPU fuse writes dropped.
    fuse_wr = act_go & act_dbg & act_req.wr & rt.src == SRC_FUSE;
    // (R22) User page byte writes.
    user_wr = act_go & act_req.wr & rt.src == SRC_USER;
  end

  // ---------------------------------------------------------------
  // Memory port
  // ---------------------------------------------------------------
  // (R4) Byte-wide memory port.
  // (R10) Bit op sent as one bit.
  always_comb begin
    mem_req = '0;
    mem_req.en = act_go & rt.src == SRC_MEM;
    mem_req.we = act_req.wr & ~act_req.rd;
    mem_req.flash = rt.flash;
    mem_req.bit_op = ~act_dbg & (act_req.op == OP_BIT_SET || act_req.op == OP_BIT_CLR);
    mem_req.bit_val = act_req.op == OP_BIT_SET;
    mem_req.addr = rt.addr;
    mem_req.wdata = act_req.wdata;
  end

  malc_gp_store #(
    .NUM(4)
  ) u_gps (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(gps_wr),
    .bit_en(gps_bit),
    .bit_val(act_req.op == OP_BIT_SET),
    .idx(act_req.addr[1:0]),
    .bit_idx(act_req.wdata[2:0]),
    .wdata(act_req.wdata),
    .val(gps_val)
  );

  // ---------------------------------------------------------------
  // Nonvolatile fuses and user page
  // ---------------------------------------------------------------
  // These model nonvolatile cells, so only power-on clears them; a system
  // reset must not wipe programmed values.
  // (R17) Erase restores the key.
  always_ff @(posedge mclk) begin
    if (!por_b) begin
      for (int i = 0; i < NUM_FUSES; i++) begin
        fuse_reg[i] <= `MALC_FUSE_ERASED;
      end
      fuse_reg[`MALC_FUSE_LOCK_IDX] <= LOCK_KEY;
    end else if (erase_go) begin
      fuse_reg[`MALC_FUSE_LOCK_IDX] <= LOCK_KEY;
    end else if (fuse_wr) begin
      fuse_reg[act_req.addr[FW-1:0]] <= act_req.wdata;
    end
  end

  // (R5) Erase leaves page alone.
  always_ff @(posedge mclk) begin
    if (!por_b) begin
      user_reg <= {USER_BYTES{`MALC_USER_ERASED}};
    end else if (user_wr) begin
      user_reg[act_req.addr[UW-1:0]] <= act_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Start-up load and lock state
  // ---------------------------------------------------------------
  // (R19) Copy fuses at start-up.
  // (R20) Targets only load here.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= ST_LOAD;
      load_idx_reg <= '0;
      cfg_out <= '0;
    end else begin
      case (state_reg)
        ST_LOAD: begin
          cfg_out[load_idx_reg] <= fuse_reg[load_idx_reg];
          load_idx_reg <= load_idx_reg + 1'b1;
          if (load_idx_reg == FW'(NUM_FUSES - 1)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_LOAD;
      endcase
    end
  end

  // Locked is assumed until the lock field is read, so nothing leaks early.
  // (R14) Any non-key value locks.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      locked_reg <= 1'b1;
    end else if (erase_go) begin
      locked_reg <= 1'b0;
    end else if (state_reg == ST_LOAD && load_idx_reg == FW'(NUM_FUSES - 1)) begin
      locked_reg <= fuse_reg[`MALC_FUSE_LOCK_IDX] != LOCK_KEY;
    end
  end

  // (R17) Erase clears application data.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mem_erase <= 1'b0;
    end else begin
      mem_erase <= erase_go;
    end
  end

  assign locked = locked_reg;
  assign started = state_reg == ST_RUN;

  // ---------------------------------------------------------------
  // Read data and answer pipeline
  // ---------------------------------------------------------------
  // (R6) Separate signature space.
  // (R15) Blocked reads give junk.
  always_comb begin
    case (rt.src)
      SRC_GPS: int_data = gps_val[act_req.addr[1:0]];
      SRC_FUSE: int_data = fuse_reg[act_req.addr[FW-1:0]];
      SRC_SIG: int_data = SIG_VALUE[8*(2-act_req.addr[1:0]) +: 8];
      SRC_USER: int_data = user_reg[act_req.addr[UW-1:0]];
      SRC_SIB: int_data = SIB_VALUE[8*act_req.addr[1:0] +: 8];
      SRC_BLOCK: int_data = `MALC_BLOCKED_DATA;
      default: int_data = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      p1_valid <= 1'b0;
      p1_dbg <= 1'b0;
      p1_src <= SRC_NONE;
      p1_data <= 8'h00;
    end else begin
      p1_valid <= act_go & act_req.rd;
      p1_dbg <= act_dbg;
      p1_src <= rt.src;
      p1_data <= int_data;
    end
  end

  // Memory data arrives one cycle after the request, so it is merged here.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cpu_rvalid <= 1'b0;
      cpu_rdata <= 8'h00;
      dbg_rvalid <= 1'b0;
      dbg_rdata <= 8'h00;
    end else begin
      cpu_rvalid <= p1_valid & ~p1_dbg;
      dbg_rvalid <= p1_valid & p1_dbg;
      if (p1_valid & ~p1_dbg) begin
        cpu_rdata <= (p1_src == SRC_MEM) ? mem_rdata : p1_data;
      end
      if (p1_valid & p1_dbg) begin
        dbg_rdata <= (p1_src == SRC_MEM) ? mem_rdata : p1_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Instruction fetch
  // ---------------------------------------------------------------
  // (R2) Full-width fetch address.
  // (R1) One 16-bit word a fetch.
  assign fetch_addr = fetch_pc;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fetch_valid <= 1'b0;
      fetch_word <= 16'h0000;
    end else begin
      fetch_valid <= fetch_en & started;
      if (fetch_en & started) begin
        fetch_word <= fetch_word_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_blocked_read;
    act_go && act_dbg && locked_reg && act_req.rd && act_req.space == SP_DATA
      |-> ##2 dbg_rvalid && dbg_rdata == 8'hFF;
  endproperty
  a_blocked_read: assert property (p_blocked_read) else $error("locked read not junk"); // (R15)

  property p_cpu_no_fuse;
    act_go && !act_dbg && act_req.wr && act_req.space == SP_FUSE |=> $stable(fuse_reg);
  endproperty
  a_cpu_no_fuse: assert property (p_cpu_no_fuse) else $error("CPU changed a fuse"); // (R18)

  property p_cfg_hold;
    state_reg == ST_RUN && $past(state_reg) == ST_RUN |-> $stable(cfg_out);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved after start-up"); // (R20)

  property p_erase_unlock;
    erase_go |=> !locked_reg && mem_erase;
  endproperty
  a_erase_unlock: assert property (p_erase_unlock) else $error("erase did not unlock"); // (R17)

  property p_user_keep;
    erase_go && !user_wr |=> $stable(user_reg);
  endproperty
  a_user_keep: assert property (p_user_keep) else $error("erase touched user page"); // (R5)

  property p_short_io;
    act_go && !act_dbg && act_req.op == OP_IO_SHORT && act_req.space == SP_DATA
      && act_req.addr > 16'h003F |-> !mem_req.en;
  endproperty
  a_short_io: assert property (p_short_io) else $error("short I/O beyond 0x3F"); // (R8)

  property p_ext_io;
    act_go && !act_dbg && act_req.op == OP_NORMAL && act_req.space == SP_DATA
      && act_req.addr >= 16'h0040 && act_req.addr <= 16'h0FFF
      |-> mem_req.en && !mem_req.flash && mem_req.addr == act_req.addr;
  endproperty
  a_ext_io: assert property (p_ext_io) else $error("extended I/O misrouted"); // (R9)

  property p_flash_map;
    act_go && !act_dbg && act_req.op == OP_NORMAL && act_req.space == SP_DATA
      && act_req.addr[15] |-> mem_req.flash && mem_req.addr == {1'b0, act_req.addr[14:0]};
  endproperty
  a_flash_map: assert property (p_flash_map) else $error("flash window offset wrong"); // (R3)

  property p_lock_load;
    state_reg == ST_LOAD && load_idx_reg == FW'(NUM_FUSES - 1) && !erase_go
      |=> locked_reg == (fuse_reg[10] != LOCK_KEY) && started;
  endproperty
  a_lock_load: assert property (p_lock_load) else $error("lock not taken from key"); // (R14)
endmodule
`default_nettype wire

// [rtl/malc_map.svh]
// Address map, field positions, reset values and fixed figures of the access/lock block.
`ifndef MALC_MAP_SVH
`define MALC_MAP_SVH
// ---------------------------------------------------------------
// Data space map
// ---------------------------------------------------------------
`define MALC_FLASH_LDST_BASE 16'h8000
`define MALC_PMLOAD_BASE 16'h0000
`define MALC_IO_SHORT_LAST 16'h003F
`define MALC_IO_EXT_FIRST 16'h0040
`define MALC_IO_EXT_LAST 16'h0FFF
`define MALC_BIT_IO_LAST 16'h001F
// ---------------------------------------------------------------
// General purpose store registers
// ---------------------------------------------------------------
`define MALC_GPS_BASE 16'h001C
`define MALC_GPS_OFS0 16'h0000
`define MALC_GPS_OFS1 16'h0001
`define MALC_GPS_OFS2 16'h0002
`define MALC_GPS_OFS3 16'h0003
`define MALC_GPS_RESET 8'h00
// ---------------------------------------------------------------
// Fuses, signature page, blocked answers
// ---------------------------------------------------------------
`define MALC_FUSE_LOCK_IDX 4'hA
`define MALC_FUSE_ERASED 8'hFF
`define MALC_USER_ERASED 8'hFF
`define MALC_SIG_BYTES 3
`define MALC_SIB_BYTES 4
`define MALC_BLOCKED_DATA 8'hFF
`define MALC_READ_LATENCY 2
`endif

// [rtl/malc_pkg.sv]
// Types shared by the access/lock block: spaces, operations, requests and memory port.
package malc_pkg;
  typedef enum logic [2:0] {
    SP_DATA = 3'b000,
    SP_SIG  = 3'b001,
    SP_FUSE = 3'b010,
    SP_USER = 3'b011,
    SP_SIB  = 3'b100
  } malc_space_e;

  typedef enum logic [2:0] {
    OP_NORMAL = 3'b000,
    OP_PMLOAD = 3'b001,
    OP_IO_SHORT = 3'b010,
    OP_BIT_SET = 3'b011,
    OP_BIT_CLR = 3'b100
  } malc_op_e;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_MEM = 3'b001,
    SRC_GPS = 3'b010,
    SRC_FUSE = 3'b011,
    SRC_SIG = 3'b100,
    SRC_USER = 3'b101,
    SRC_SIB = 3'b110,
    SRC_BLOCK = 3'b111
  } malc_src_e;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN = 2'b01
  } malc_state_e;

  typedef struct packed {
    logic rd;
    logic wr;
    malc_space_e space;
    malc_op_e op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } malc_req_s;

  typedef struct packed {
    logic en;
    logic we;
    logic flash;
    logic bit_op;
    logic bit_val;
    logic [15:0] addr;
    logic [7:0] wdata;
  } malc_mem_s;

  typedef struct packed {
    malc_src_e src;
    logic [15:0] addr;
    logic flash;
  } malc_route_s;
endpackage

// [rtl/malc_gp_store.sv]
// Four bit-addressable general purpose store registers.
`timescale 1ns/1ps
`default_nettype none
`include "malc_map.svh"
module malc_gp_store
  import malc_pkg::*;
#(
  parameter int NUM = 4
)(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic bit_en,
  input wire logic bit_val,
  input wire logic [1:0] idx,
  input wire logic [2:0] bit_idx,
  input wire logic [7:0] wdata,
  output logic [NUM-1:0][7:0] val
);
  if (NUM != 4) begin : g_bad_num
    $error("malc_gp_store serves exactly four registers");
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // (R12) Reset to zero, byte writes.
  // (R10) Bit ops touch one bit.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      val <= {NUM{`MALC_GPS_RESET}};
    end else if (bit_en) begin
      val[idx][bit_idx] <= bit_val; // Neighbouring bits keep their value.
    end else if (wr_en) begin
      val[idx] <= wdata;
    end
  end

  // Only the addressed bit may move on a bit operation.
  property p_bit_only;
    @(posedge mclk) disable iff (!rst_b)
    bit_en |=> ((val[$past(idx)] ^ $past(val[idx])) & ~(8'h01 << $past(bit_idx))) == 8'h00;
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("bit op disturbed other bits"); // (R10)
endmodule
`default_nettype wire

// [verif/malc_mem_model.sv]
// Behavioural memory standing behind the block's memory request port.
`timescale 1ns/1ps
`default_nettype none
module malc_mem_model
  import malc_pkg::*;
(
  input wire logic mclk,
  input wire malc_mem_s mem_req,
  input wire logic mem_erase,
  output logic [7:0] mem_rdata
);
  // Flash and data bytes are kept apart by the flash flag in the key.
  logic [7:0] mem [logic [16:0]];
  initial mem_rdata = 8'h00;

  // Byte-wide store; an unselected cycle shows the inverse, never stale data.
  // byte access
  always @(posedge mclk) begin
    if (mem_erase) begin
      mem.delete();
    end else if (mem_req.en && mem_req.we && mem_req.bit_op) begin
      mem[{mem_req.flash, mem_req.addr}][mem_req.wdata[2:0]] = mem_req.bit_val;
    end else if (mem_req.en && mem_req.we) begin
      mem[{mem_req.flash, mem_req.addr}] = mem_req.wdata;
    end
    if (mem_req.en && !mem_req.we) begin
      mem_rdata <= mem.exists({mem_req.flash, mem_req.addr}) ?
        mem[{mem_req.flash, mem_req.addr}] : 8'hFF;
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// [verif/malc_top_tb.sv]
// Self-checking bench for the memory access and lock control block.
`timescale 1ns/1ps
`default_nettype none
`include "malc_map.svh"
module malc_top_tb
  import malc_pkg::*;
;
  localparam logic [7:0] KEY = 8'hC5;
  localparam logic [23:0] SIG = 24'h5A0102; // Arbitrary value.
  localparam logic [31:0] SYSTEM_INFO_BLOCK = 32'h00A1B2C3; // Arbitrary value.
  logic mclk = 1'b0;
  logic rst_b, por_b, dbg_erase, fetch_en;
  malc_req_s cpu_req, dbg_req;
  logic [10:0] fetch_pc, fetch_addr;
  logic [15:0] fetch_word_in, fetch_word;
  logic cpu_ready, cpu_rvalid, dbg_ready, dbg_rvalid, fetch_valid, mem_erase, locked, started;
  logic [7:0] cpu_rdata, dbg_rdata, mem_rdata;
  malc_mem_s mem_req;
  logic [10:0][7:0] cfg_out;
  int num_errors = 0;
  int check_count = 0;

  always #2 mclk = ~mclk;

  malc_top #(.LOCK_KEY(KEY), .SIG_VALUE(SIG), .SIB_VALUE(SYSTEM_INFO_BLOCK)) dut (.mclk(mclk),
    .rst_b(rst_b), .por_b(por_b), .cpu_req(cpu_req), .cpu_ready(cpu_ready),
    .cpu_rvalid(cpu_rvalid), .cpu_rdata(cpu_rdata), .dbg_req(dbg_req),
    .dbg_ready(dbg_ready), .dbg_rvalid(dbg_rvalid), .dbg_rdata(dbg_rdata),
    .dbg_erase(dbg_erase), .fetch_en(fetch_en), .fetch_pc(fetch_pc),
    .fetch_addr(fetch_addr), .fetch_word_in(fetch_word_in), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .mem_erase(mem_erase), .cfg_out(cfg_out), .locked(locked), .started(started));

  malc_mem_model mem_i (.mclk(mclk), .mem_req(mem_req), .mem_erase(mem_erase),
    .mem_rdata(mem_rdata));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Waits for start-up; fuses are copied one per edge, so 40 edges is ample.
  task automatic boot();
    int n;
    n = 0;
    while (started !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(started, 1'b1);
  endtask

  // One access from either side; a read checks the answered byte.
  task automatic acc(input bit d, input bit w, input malc_space_e sp,
                     input logic [15:0] a, input logic [7:0] wd, input logic [7:0] ex);
    malc_req_s r;
    int n;
    r = '{rd: !w, wr: w, space: sp, op: OP_NORMAL, addr: a, wdata: wd};
    @(posedge mclk);
    if (d) dbg_req <= r;
    else cpu_req <= r;
    @(posedge mclk);
    dbg_req <= '0;
    cpu_req <= '0;
    if (!w) begin
      // Poll off the edge, so a pulse ending at this edge is not taken for the answer.
      n = 0;
      @(negedge mclk);
      while ((d ? dbg_rvalid : cpu_rvalid) !== 1'b1 && n < 4) begin
        @(negedge mclk);
        n++;
      end
      chk(n == 1, 1'b1);
      chk(d ? dbg_rdata : cpu_rdata, ex);
    end
  endtask

  // CPU data request; checks {en, flash, addr} on the memory port in its cycle.
  task automatic mq(input bit w, input malc_op_e op, input logic [15:0] a,
                    input logic [7:0] wd, input logic [17:0] ex);
    @(posedge mclk);
    cpu_req <= '{rd: !w, wr: w, space: SP_DATA, op: op, addr: a, wdata: wd};
    @(negedge mclk);
    chk({mem_req.en, mem_req.flash, mem_req.addr}, ex);
    chk({cpu_ready, dbg_ready}, 2'b10);
    @(posedge mclk);
    cpu_req <= '0;
  endtask

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #20000;
    num_errors++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    por_b = 1'b0;
    cpu_req = '0;
    dbg_req = '0;
    dbg_erase = 1'b0;
    fetch_en = 1'b0;
    fetch_pc = '0;
    fetch_word_in = '0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    boot();
    chk(locked, 1'b0);
    chk(cfg_out[0], 8'hFF);
    chk(cfg_out[10], KEY);
    for (int i = 0; i < 4; i++) acc(0, 0, SP_DATA, 16'h001C + i, 0, `MALC_GPS_RESET);
    // Stores keep every other bit through single-bit set and clear.
    acc(0, 1, SP_DATA, 16'h001C, 8'hA5, 0);
    mq(1, OP_BIT_SET, 16'h001C, 8'h01, {2'b00, 16'h001C});
    mq(1, OP_BIT_CLR, 16'h001C, 8'h00, {2'b00, 16'h001C});
    acc(0, 0, SP_DATA, 16'h001C, 0, 8'hA6);
    mq(1, OP_BIT_SET, 16'h0020, 8'h01, {2'b00, 16'h0020});
    mq(1, OP_BIT_SET, 16'h0010, 8'h01, {2'b10, 16'h0010});
    mq(1, OP_IO_SHORT, 16'h003F, 8'h11, {2'b10, 16'h003F});
    mq(1, OP_IO_SHORT, 16'h0040, 8'h11, {2'b00, 16'h0040});
    mq(1, OP_NORMAL, 16'h0FFF, 8'h11, {2'b10, 16'h0FFF});
    mq(1, OP_NORMAL, 16'h8010, 8'h11, {2'b11, 16'h0010});
    mq(0, OP_PMLOAD, 16'h0010, 8'h00, {2'b11, 16'h0010});
    acc(0, 0, SP_DATA, 16'h8010, 0, 8'h11);
    for (int i = 0; i < 3; i++) acc(0, 0, SP_SIG, i, 0, SIG[23 - 8 * i -: 8]);
    acc(0, 1, SP_SIG, 16'h0000, 8'h00, 0);
    acc(1, 1, SP_SIG, 16'h0001, 8'h00, 0);
    acc(1, 0, SP_SIG, 16'h0000, 0, SIG[23:16]);
    acc(0, 0, SP_SIG, 16'h0001, 0, SIG[15:8]);
    // Fuses: only the debug side programs them, effective after a reset.
    acc(0, 1, SP_FUSE, 16'h0000, 8'h12, 0);
    acc(0, 0, SP_FUSE, 16'h0000, 0, 8'hFF);
    acc(1, 1, SP_FUSE, 16'h0000, 8'h12, 0);
    acc(0, 0, SP_FUSE, 16'h0000, 0, 8'h12);
    acc(1, 1, SP_FUSE, 16'h000A, 8'h00, 0);
    chk(cfg_out[0], 8'hFF);
    chk(locked, 1'b0);
    @(posedge mclk) rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    boot();
    chk(cfg_out[0], 8'h12);
    chk(locked, 1'b1);
    // Locked: debug reads outside the information block give the blocked byte, CPU keeps working.
    acc(1, 0, SP_DATA, 16'h001C, 0, 8'hFF);
    acc(1, 0, SP_DATA, 16'h8010, 0, 8'hFF);
    acc(0, 0, SP_DATA, 16'h8010, 0, 8'h11);
    acc(1, 0, SP_FUSE, 16'h0000, 0, 8'hFF);
    acc(1, 0, SP_SIG, 16'h0000, 0, 8'hFF);
    acc(1, 0, SP_SIB, 16'h0000, 0, SYSTEM_INFO_BLOCK[7:0]);
    acc(1, 0, SP_SIB, 16'h0003, 0, SYSTEM_INFO_BLOCK[31:24]);
    acc(1, 1, SP_DATA, 16'h001D, 8'h77, 0);
    acc(0, 0, SP_DATA, 16'h001D, 0, 8'h00);
    acc(1, 1, SP_USER, 16'h0005, 8'h3C, 0);
    acc(1, 0, SP_USER, 16'h0005, 0, 8'hFF);
    acc(0, 0, SP_USER, 16'h0005, 0, 8'h3C);
    // Full erase unlocks, wipes memory and spares the user page.
    @(posedge mclk) dbg_erase <= 1'b1;
    @(posedge mclk) dbg_erase <= 1'b0;
    @(negedge mclk) chk(mem_erase, 1'b1);
    chk(locked, 1'b0);
    acc(1, 0, SP_USER, 16'h0005, 0, 8'h3C);
    acc(1, 0, SP_DATA, 16'h8010, 0, 8'hFF);
    // Instruction fetch returns a whole word one cycle later.
    @(posedge mclk);
    fetch_en <= 1'b1;
    fetch_pc <= 11'h7FF;
    fetch_word_in <= 16'hBEEF;
    @(negedge mclk) chk(fetch_addr, 11'h7FF);
    @(posedge mclk) fetch_en <= 1'b0;
    @(negedge mclk) chk(fetch_valid, 1'b1);
    chk(fetch_word, 16'hBEEF);
    wrap_up();
  end
endmodule
`default_nettype wire
